/* include/wwdt_pkg.sv */
// Package for the windowed watchdog timer: timing constants, field
// positions, the low-power mode encoding and the carrier structs.
// Assumes one 125 MHz system clock from which every slower rate is an
// enable pulse.
package wwdt_pkg;

   // System clock and the emulated low-power RC oscillator rate
   localparam int unsigned CLK_HZ       = 125_000_000;
   localparam int unsigned LOW_POWER_RC_OSC_OSC_HZ  = 31_000;       // Nominal 31 kHz
   localparam int unsigned OSC_DIV_W    = 12;           // Divider width
   // Cycles of the system clock per oscillator tick, minus one
   localparam logic [OSC_DIV_W-1:0] OSC_DIV_M1 =
      OSC_DIV_W'(CLK_HZ / LOW_POWER_RC_OSC_OSC_HZ - 1);

   // Prescaler: 5-bit (divide-by-32) or 7-bit (divide-by-128)
   localparam int unsigned PRE_W          = 7;
   localparam logic [PRE_W-1:0] PRE_SHORT_TOP = 7'h1f;  // Divide by 32
   localparam logic [PRE_W-1:0] PRE_LONG_TOP  = 7'h7f;  // Divide by 128
   localparam logic [2:0]   PRE_SHORT_SHIFT = 3'h5;
   localparam logic [2:0]   PRE_LONG_SHIFT  = 3'h7;
   // Base time-out period per prescaler setting, in milliseconds
   localparam int unsigned BASE_TIMEOUT_SHORT_MS = 1;
   localparam int unsigned BASE_TIMEOUT_LONG_MS  = 4;

   // Postscaler: 16 ratios, 1:1 up to 1:32,768
   localparam int unsigned POST_W     = 15;
   localparam logic [3:0]  POST_MAX_SEL = 4'hf;
   // Elapsed oscillator ticks within one full period
   localparam int unsigned ELAPSED_W  = 23;

   // Layout of configuration word one
   localparam int unsigned CW1_W          = 8;
   localparam int unsigned CW1_POST_LSB   = 0;   // Postscale ratio <3:0>
   localparam int unsigned CW1_WINDOW_DISABLE_CFG_BIT = 6;   // Window disable

   // Power mode of the core, one-hot
   typedef enum logic [2:0] {
      MODE_RUN   = 3'b001,
      MODE_SLEEP = 3'b010,
      MODE_IDLE  = 3'b100
   } wwdt_mode_e;

   // Instruction events from the processor core, one-cycle pulses
   typedef struct packed {
      logic clear_instr;      // Watchdog clear instruction executed
      logic power_save_instr; // Power-save instruction executed
      logic power_save_idle;  // With power_save_instr: 1 idle, 0 sleep
      logic wake_exit;        // Core leaves sleep/idle for another cause
      logic osc_switch_go;    // A clock switch has completed
   } wwdt_cpu_s;

   // Decoded configuration
   typedef struct packed {
      logic       watchdog_enable;
      logic       prescale_long;
      logic       window_disable;
      logic [3:0] postscale_ratio;
   } wwdt_cfg_s;

endpackage

/* rtl/wwdt_prescaler.sv */
// Emulated low-power RC oscillator tick and the watchdog prescaler.
// Assumes the caller holds osc_on_i low whenever the watchdog is off and
// pulses clr_i whenever the watchdog counts must restart.
module wwdt_prescaler (
   input  wire logic                      clk_i,     // System clock
   input  wire logic                      rst_i,     // Sync reset, high
   input  wire logic                      osc_on_i,  // Oscillator enable
   input  wire logic                      clr_i,     // Clear prescaler
   input  wire logic                      long_i,    // 1 div-128, 0 div-32
   output      logic [wwdt_pkg::PRE_W-1:0] cnt_o,    // Prescaler count
   output      logic                      tick_o     // Prescaler wrap
);

   logic [wwdt_pkg::OSC_DIV_W-1:0] osc_q;  // Oscillator phase
   logic [wwdt_pkg::OSC_DIV_W-1:0] osc_d;
   logic [wwdt_pkg::PRE_W-1:0]     pre_q;  // Prescaler count
   logic [wwdt_pkg::PRE_W-1:0]     pre_d;
   wire                            osc_tick; // One pulse per osc period
   wire  [wwdt_pkg::PRE_W-1:0]     pre_top;  // Last count of the divider
   wire                            pre_wrap;

   // The oscillator only runs while the watchdog wants it
   assign osc_tick = osc_on_i && (osc_q == wwdt_pkg::OSC_DIV_M1);
   assign osc_d    = osc_tick ? '0 : osc_q + 1'b1;

   // Divider length picked by the prescale select bit
   assign pre_top  = long_i ? wwdt_pkg::PRE_LONG_TOP
                            : wwdt_pkg::PRE_SHORT_TOP;
   assign pre_wrap = osc_tick && (pre_q == pre_top);
   assign pre_d    = pre_wrap ? '0 : pre_q + 1'b1;

   assign cnt_o  = pre_q;
   assign tick_o = pre_wrap;

   // Oscillator phase: parked at zero while the oscillator is off
   always_ff @(posedge clk_i) begin
      if (rst_i || !osc_on_i) begin
         osc_q <= '0;
      end else begin
         osc_q <= osc_d;
      end
   end

   // Prescaler counts oscillator ticks; clear restarts it
   always_ff @(posedge clk_i) begin
      if (rst_i || clr_i) begin
         pre_q <= '0;
      end else if (osc_tick) begin
         pre_q <= pre_d;
      end
   end

endmodule

/* rtl/wwdt_top.sv */
// Windowed watchdog timer: enable logic, postscaler, window check,
// time-out handling, power mode tracking and sticky status flags.
// Assumes the core reports its instructions as one-cycle pulses and that
// the system returns any device reset, including ours, on DEV_RST_I.
module wwdt_top (
   input  wire logic                        MCLK_I,             // Clock
   input  wire logic                        SRST_I,             // POR
   input  wire logic                        DEV_RST_I,          // Dev reset
   input  wire logic [wwdt_pkg::CW1_W-1:0]  CONFIG_WORD_ONE_I,  // Cfg 1
   input  wire logic                        WDT_EN_CFG_I,       // Always on
   input  wire logic                        PRESCALE_SEL_CFG_I, // 1 div-128
   input  wire wwdt_pkg::wwdt_cpu_s         CPU_I,              // Core evts
   input  wire logic                        SW_ON_WR_I,         // Write en
   input  wire logic                        SW_ON_DATA_I,       // En value
   input  wire logic                        TO_FLAG_CLR_I,      // Clr flag
   input  wire logic                        SLEEP_FLAG_CLR_I,   // Clr sleep
   input  wire logic                        IDLE_FLAG_CLR_I,    // Clr idle
   output      logic                        WDT_RESET_O,        // Reset req
   output      logic                        WAKE_O,             // Wake pulse
   output      logic                        TIMEOUT_FLAG_O,     // Sticky
   output      logic                        SLEEP_FLAG_O,       // Status
   output      logic                        IDLE_FLAG_O,        // Status
   output      logic                        SW_ON_O,            // Sw enable
   output      logic                        LOW_POWER_RC_OSC_ON_O,          // Osc on
   output      logic                        RUNNING_O           // Enabled
);

   // Scale a count of prescaler periods into oscillator ticks
   function automatic logic [wwdt_pkg::ELAPSED_W-1:0] to_ticks(
      input logic [wwdt_pkg::ELAPSED_W-1:0] v,
      input logic                           long_sel
   );
      logic [2:0] sh;
      sh = long_sel ? wwdt_pkg::PRE_LONG_SHIFT : wwdt_pkg::PRE_SHORT_SHIFT;
      return v << sh;
   endfunction

   // Configuration decoded from the ports
   wwdt_pkg::wwdt_cfg_s cfg;

   // Registers
   wwdt_pkg::wwdt_mode_e          mode_q;       // Core power mode
   wwdt_pkg::wwdt_mode_e          mode_d;
   logic [wwdt_pkg::POST_W-1:0]   post_q;       // Postscaler count
   logic                          sw_on_q;      // Software enable
   logic                          to_flag_q;    // Sticky time-out
   logic                          sleep_flag_q; // Entered sleep
   logic                          idle_flag_q;  // Entered idle
   logic                          rst_out_q;    // Reset request out
   logic                          wake_out_q;   // Wake pulse out
   logic                          osc_on_q;     // Oscillator enable out
   logic                          run_q;        // Enabled, registered

   // Prescaler side
   logic [wwdt_pkg::PRE_W-1:0]    pre_cnt;      // Prescaler count
   logic                          pre_tick;     // One prescaled period

   // Decode and event wires
   wire                           enabled;      // Watchdog runs
   wire                           in_run;       // Core executing
   wire  [wwdt_pkg::POST_W-1:0]   post_last;    // Last postscale count
   wire  [wwdt_pkg::ELAPSED_W-1:0] elapsed;     // Ticks since restart
   wire  [wwdt_pkg::ELAPSED_W-1:0] period;      // Ticks per time-out
   wire  [wwdt_pkg::ELAPSED_W-1:0] win_start;   // Start of last quarter
   wire                           win_open;     // Clear is allowed now
   wire                           clr_valid;    // Clear instr accepted
   wire                           clr_early;    // Clear before window
   wire                           timeout;      // Full period elapsed
   wire                           fire_rst;     // Watchdog device reset
   wire                           fire_wake;    // Watchdog wake-up
   wire                           enter_save;   // Entering sleep or idle
   wire                           leave_save;   // Leaving sleep or idle
   wire                           cnt_clr;      // Restart all counts

   // Enable and prescale select from their ports; window and postscale fields from word one
   assign cfg.watchdog_enable = WDT_EN_CFG_I;
   assign cfg.prescale_long   = PRESCALE_SEL_CFG_I;
   assign cfg.window_disable  =
      CONFIG_WORD_ONE_I[wwdt_pkg::CW1_WINDOW_DISABLE_CFG_BIT];
   assign cfg.postscale_ratio =
      CONFIG_WORD_ONE_I[wwdt_pkg::CW1_POST_LSB +: 4];

   // Hardware enable overrides; otherwise software decides
   assign enabled = cfg.watchdog_enable || sw_on_q;
   assign in_run  = (mode_q == wwdt_pkg::MODE_RUN);

   // Postscale ratio 2^n, so the last count is 2^n - 1
   assign post_last = {wwdt_pkg::POST_W{1'b1}}
                      >> (wwdt_pkg::POST_MAX_SEL - cfg.postscale_ratio);

   // Progress measured in oscillator ticks so that the quarter window
   // stays exact even at the 1:1 and 1:2 ratios
   assign elapsed   = to_ticks(wwdt_pkg::ELAPSED_W'(post_q),
                               cfg.prescale_long)
                    + wwdt_pkg::ELAPSED_W'(pre_cnt);
   assign period    = to_ticks(wwdt_pkg::ELAPSED_W'(post_last) + 1'b1,
                               cfg.prescale_long);
   assign win_start = period - (period >> 2);
   assign win_open  = (elapsed >= win_start);

   // A clear only counts while executing with the watchdog running
   assign clr_valid = CPU_I.clear_instr && in_run && enabled;
   // Window active when the disable bit is zero early clear
   assign clr_early = clr_valid && !cfg.window_disable && !win_open;

   // Time-out at the wrap of the last prescaled period
   assign timeout   = enabled && pre_tick && (post_q == post_last);

   // Running: reset the device early clear acts alike
   assign fire_rst  = (timeout && in_run) || clr_early;
   // Asleep or idle: wake instead of reset
   assign fire_wake = timeout && !in_run;

   assign enter_save = CPU_I.power_save_instr && in_run;
   assign leave_save = !in_run && (fire_wake || CPU_I.wake_exit);

   // Every restart cause clears prescaler and postscaler together
   assign cnt_clr = DEV_RST_I || CPU_I.osc_switch_go || enter_save
                 || leave_save || clr_valid || fire_rst || !enabled;

   // Mode tracking: enter on power-save, leave on wake
   always_comb begin
      mode_d = mode_q;
      unique case (mode_q)
         wwdt_pkg::MODE_RUN: begin
            if (enter_save) begin
               mode_d = CPU_I.power_save_idle ? wwdt_pkg::MODE_IDLE
                                              : wwdt_pkg::MODE_SLEEP;
            end
         end
         wwdt_pkg::MODE_SLEEP, wwdt_pkg::MODE_IDLE: begin
            if (leave_save) begin
               mode_d = wwdt_pkg::MODE_RUN;  // Resume after power-save
            end
         end
         default: mode_d = wwdt_pkg::MODE_RUN; // Recover from bad code
      endcase
   end

   // Oscillator and prescaler
   wwdt_prescaler u_pre (
      .clk_i    (MCLK_I),
      .rst_i    (SRST_I),
      .osc_on_i (enabled),       // Oscillator follows the enable
      .clr_i    (cnt_clr),
      .long_i   (cfg.prescale_long),
      .cnt_o    (pre_cnt),
      .tick_o   (pre_tick)
   );

   // Power mode register; a device reset returns to executing
   always_ff @(posedge MCLK_I) begin
      if (SRST_I || DEV_RST_I) begin
         mode_q <= wwdt_pkg::MODE_RUN;
      end else begin
         mode_q <= mode_d;
      end
   end

   // Postscaler counts prescaled periods, also in sleep/idle
   always_ff @(posedge MCLK_I) begin
      if (SRST_I || cnt_clr) begin
         post_q <= '0;
      end else if (pre_tick) begin
         post_q <= post_q + 1'b1;
      end
   end

   // Software enable, lost on any device reset
   always_ff @(posedge MCLK_I) begin
      if (SRST_I || DEV_RST_I) begin
         sw_on_q <= 1'b0;
      end else if (SW_ON_WR_I) begin
         sw_on_q <= SW_ON_DATA_I;
      end
   end

   // Sticky time-out flag; survives the reset it causes, set beats
   // clear, and only power-on or software clears it
   always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
         to_flag_q <= 1'b0;
      end else if (fire_rst || fire_wake) begin
         to_flag_q <= 1'b1;
      end else if (TO_FLAG_CLR_I) begin
         to_flag_q <= 1'b0;
      end
   end

   // Sleep and idle status stay set through wake-up; software clears
   // them, and a new entry in the same cycle wins
   always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
         sleep_flag_q <= 1'b0;
         idle_flag_q  <= 1'b0;
      end else begin
         if (enter_save && !CPU_I.power_save_idle) begin
            sleep_flag_q <= 1'b1;
         end else if (SLEEP_FLAG_CLR_I) begin
            sleep_flag_q <= 1'b0;
         end
         if (enter_save && CPU_I.power_save_idle) begin
            idle_flag_q <= 1'b1;
         end else if (IDLE_FLAG_CLR_I) begin
            idle_flag_q <= 1'b0;
         end
      end
   end

   // Registered outputs: one-cycle event pulses and status levels
   always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
         rst_out_q  <= 1'b0;
         wake_out_q <= 1'b0;
         osc_on_q   <= 1'b0;
         run_q      <= 1'b0;
      end else begin
         rst_out_q  <= fire_rst;
         wake_out_q <= fire_wake;
         osc_on_q   <= enabled;
         run_q      <= enabled;
      end
   end

   assign WDT_RESET_O    = rst_out_q;
   assign WAKE_O         = wake_out_q;
   assign TIMEOUT_FLAG_O = to_flag_q;
   assign SLEEP_FLAG_O   = sleep_flag_q;
   assign IDLE_FLAG_O    = idle_flag_q;
   assign SW_ON_O        = sw_on_q;
   assign LOW_POWER_RC_OSC_ON_O      = osc_on_q;
   assign RUNNING_O      = run_q;

endmodule

/* bench/wwdt_assertions.sv */
// Concurrent checks on the ports of the windowed watchdog top.
// Assumes a bind to wwdt_top; everything is in the MCLK_I domain.
module wwdt_assertions (
   input wire logic                       MCLK_I,             // Clock
   input wire logic                       SRST_I,             // POR
   input wire logic                       DEV_RST_I,          // Dev reset
   input wire logic [wwdt_pkg::CW1_W-1:0] CONFIG_WORD_ONE_I,  // Cfg 1
   input wire logic                       WDT_EN_CFG_I,       // Always on
   input wire wwdt_pkg::wwdt_cpu_s        CPU_I,              // Core evts
   input wire logic                       SW_ON_WR_I,         // Write en
   input wire logic                       SW_ON_DATA_I,       // En value
   input wire logic                       TO_FLAG_CLR_I,      // Clr flag
   input wire logic                       WDT_RESET_O,        // Reset req
   input wire logic                       WAKE_O,             // Wake pulse
   input wire logic                       TIMEOUT_FLAG_O,     // Sticky
   input wire logic                       SLEEP_FLAG_O,       // Status
   input wire logic                       IDLE_FLAG_O,        // Status
   input wire logic                       SW_ON_O,            // Sw enable
   input wire logic                       LOW_POWER_RC_OSC_ON_O,          // Osc on
   input wire logic                       RUNNING_O           // Enabled
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] since_on_q; // Cycles since the watchdog came on
   logic       quiet_w;    // Core plainly in run mode
   // Flags clear means no sleep or idle has been entered yet
   assign quiet_w = !SLEEP_FLAG_O && !IDLE_FLAG_O && !DEV_RST_I
                    && !CPU_I.power_save_instr;
   // Saturating age; far below one oscillator tick a clear is early
   always_ff @(posedge MCLK_I) begin
      if (SRST_I || !RUNNING_O) since_on_q <= 10'h000;
      else if (since_on_q != 10'h3ff) since_on_q <= since_on_q + 10'h001;
   end
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (SRST_I);
   // Sampled reset in the antecedent: the attempt at the release edge
   // would otherwise see the outputs still held by reset
   AST_OSC_WITH_RUN:
      assert property (!SRST_I && (WDT_EN_CFG_I || SW_ON_O)
         |=> LOW_POWER_RC_OSC_ON_O && RUNNING_O) else $error("osc enable");
   AST_OSC_OFF:
      assert property (!SRST_I && !WDT_EN_CFG_I && !SW_ON_O
         |=> !LOW_POWER_RC_OSC_ON_O && !RUNNING_O) else $error("osc left on");
   AST_HW_ENABLE:
      assert property (WDT_EN_CFG_I && !DEV_RST_I ##1 WDT_EN_CFG_I
         && !DEV_RST_I |=> RUNNING_O) else $error("hw enable lost");
   AST_SW_ENABLE:
      assert property (SW_ON_WR_I && SW_ON_DATA_I && !DEV_RST_I
         |=> SW_ON_O ##1 RUNNING_O) else $error("sw enable late");
   AST_SW_RESET:
      assert property (DEV_RST_I |=> !SW_ON_O) else $error("sw enable kept");
   AST_PULSE_FLAG:
      assert property (WDT_RESET_O || WAKE_O |-> TIMEOUT_FLAG_O)
         else $error("flag missing");
   AST_STICKY:
      assert property (TIMEOUT_FLAG_O && !TO_FLAG_CLR_I |=> TIMEOUT_FLAG_O)
         else $error("flag dropped");
   AST_FLAG_CAUSE:
      assert property ($rose(TIMEOUT_FLAG_O) |-> WDT_RESET_O || WAKE_O)
         else $error("flag without event");
   AST_WAKE_ASLEEP:
      assert property (WAKE_O |-> (SLEEP_FLAG_O || IDLE_FLAG_O)
         && !WDT_RESET_O) else $error("wake while running");
   AST_SLEEP_ENTRY:
      assert property (CPU_I.power_save_instr && !CPU_I.power_save_idle
         && !SLEEP_FLAG_O && !IDLE_FLAG_O && !DEV_RST_I
         |=> SLEEP_FLAG_O && !IDLE_FLAG_O) else $error("sleep flag");
   AST_EARLY_CLEAR:
      assert property (CPU_I.clear_instr && !CONFIG_WORD_ONE_I[6]
         && RUNNING_O && quiet_w && since_on_q < 10'h3e8
         |=> WDT_RESET_O && TIMEOUT_FLAG_O) else $error("early clear");
   AST_WINDOW_OFF:
      assert property (CPU_I.clear_instr && CONFIG_WORD_ONE_I[6]
         && RUNNING_O && quiet_w && since_on_q < 10'h3e8
         |=> !WDT_RESET_O) else $error("clear refused");
endmodule

/* bench/wwdt_core_model.sv */
// Model of the processor core: instruction events and reset return.
// Assumes its tasks are called from the bench at a clock edge.
module wwdt_core_model (
   input  wire logic           clk_i,       // System clock
   input  wire logic           wdt_reset_i, // Watchdog reset request
   output wwdt_pkg::wwdt_cpu_s cpu_o,       // Instruction events
   output logic                dev_rst_o    // Device reset back in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cpu_o = '0;
      dev_rst_o = 1'b0;
   end
   // A reset request comes back as a one-edge device reset
   always @(posedge clk_i) dev_rst_o <= wdt_reset_i;
   // One-cycle event, taken at the second edge
   task automatic send(input logic [4:0] ev);
      @(posedge clk_i);
      cpu_o <= wwdt_pkg::wwdt_cpu_s'(ev);
      @(posedge clk_i);
      cpu_o <= '0;
   endtask
endmodule

/* bench/wwdt_top_tb.sv */
// Self-checking bench for the windowed watchdog top.
// Assumes the package is compiled first; time-outs run full length.
module wwdt_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic MCLK_I, SRST_I, DEV_RST_I, WDT_EN_CFG_I, PRESCALE_SEL_CFG_I;
   logic SW_ON_WR_I, SW_ON_DATA_I, TO_FLAG_CLR_I, SLEEP_FLAG_CLR_I;
   logic IDLE_FLAG_CLR_I, WDT_RESET_O, WAKE_O, TIMEOUT_FLAG_O;
   logic SLEEP_FLAG_O, IDLE_FLAG_O, SW_ON_O, LOW_POWER_RC_OSC_ON_O, RUNNING_O;
   logic [wwdt_pkg::CW1_W-1:0] CONFIG_WORD_ONE_I; // Config word one
   wwdt_pkg::wwdt_cpu_s        CPU_I;             // From the core model
   logic [2:0]  exp_q[$];     // Expected {reset, wake, flag}
   logic [31:0] seed = 32'h36;
   time         t0, t_evt;    // Restart and pulse times
   int          cyc;          // Measured time-out, clocks past 31 ticks
   // System clocks per oscillator tick
   localparam int OSC_CLK = int'(wwdt_pkg::OSC_DIV_M1) + 1;
   int          mismatches = 0, cmp_count = 0;
   wwdt_top i_wwdt_top (.*);
   wwdt_core_model i_wwdt_core_model (.clk_i(MCLK_I),
      .wdt_reset_i(WDT_RESET_O), .cpu_o(CPU_I), .dev_rst_o(DEV_RST_I));
   initial begin
      MCLK_I = 1'b0;
      forever #4 MCLK_I = ~MCLK_I;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   task automatic check(input logic [2:0] seen, input logic [2:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge MCLK_I);
   endtask
   // Random idle gap, unused config bits and ignored enable data; rnd
   // also draws the postscale ratio and prescale select, which only
   // tests without a full time-out can afford
   task automatic gap(input logic window_disable_cfg, input logic rnd);
      seed = xs(seed);
      CONFIG_WORD_ONE_I <= {seed[7], window_disable_cfg, seed[5:4],
                            seed[11:8] & {4{rnd}}};
      PRESCALE_SEL_CFG_I <= seed[12] & rnd;
      SW_ON_DATA_I <= seed[13]; // No effect without the write strobe
      tick(2 + seed[2:0]);
   endtask
   // Wait, bounded, for the monitor to take every note
   task automatic wait_evt;
      for (int i = 0; i < 140000 && exp_q.size() > 0; i++) tick(1);
      if (exp_q.size() > 0) check(3'h7, 3'h0);
      exp_q.delete();
   endtask
   // Every pulse takes the oldest note; an unnoted pulse is a mismatch
   always @(posedge MCLK_I) begin
      if (WDT_RESET_O === 1'b1 || WAKE_O === 1'b1) begin
         t_evt = $time;
         if (exp_q.size() == 0) check(3'h0, 3'h7);
         else check({WDT_RESET_O, WAKE_O, TIMEOUT_FLAG_O},
                    exp_q.pop_front());
      end
   end
   // Two full time-outs fit well inside this span
   initial begin
      #(8 * 400000);
      mismatches++;
      conclude();
   end
   initial begin
      {SW_ON_WR_I, SW_ON_DATA_I, TO_FLAG_CLR_I, SLEEP_FLAG_CLR_I} = '0;
      {IDLE_FLAG_CLR_I, PRESCALE_SEL_CFG_I} = '0;
      SRST_I = 1'b1;
      WDT_EN_CFG_I = 1'b1;
      CONFIG_WORD_ONE_I = 8'h40;
      tick(2);
      SRST_I <= 1'b0;
      tick(1);
      check({WDT_RESET_O, WAKE_O, TIMEOUT_FLAG_O}, 3'h0);
      // Full time-out from an accepted clear, 1:1 and divide by 32
      gap(1'b1, 1'b0);
      exp_q.push_back(3'b101);
      i_wwdt_core_model.send(5'h10);
      t0 = $time;
      wait_evt();
      // 32 osc ticks after the clear; the free-running osc phase adds up
      // to one tick of slack and the registered pulse one clock
      cyc = int'((t_evt - t0) / 8) - 31 * OSC_CLK;
      check(3'(cyc > 0 && cyc <= OSC_CLK + 1), 3'h1);
      tick(3);
      check(3'(TIMEOUT_FLAG_O), 3'h1);
      TO_FLAG_CLR_I <= 1'b1;
      tick(1);
      TO_FLAG_CLR_I <= 1'b0;
      tick(2);
      check(3'(TIMEOUT_FLAG_O), 3'h0);
      $display("test timeout done");
      // Software enable, clock switch, then an early clear in window mode
      WDT_EN_CFG_I <= 1'b0;
      gap(1'b0, 1'b1);
      check(3'(RUNNING_O), 3'h0);
      {SW_ON_WR_I, SW_ON_DATA_I} <= 2'b11;
      tick(1);
      SW_ON_WR_I <= 1'b0;
      tick(3);
      check({1'b0, RUNNING_O, LOW_POWER_RC_OSC_ON_O}, 3'h3);
      i_wwdt_core_model.send(5'h01);
      exp_q.push_back(3'b101);
      i_wwdt_core_model.send(5'h10);
      wait_evt();
      tick(3);
      check({TIMEOUT_FLAG_O, SW_ON_O, RUNNING_O}, 3'h4);
      $display("test window done");
      // Sleep: clear ignored, time-out wakes; then idle and wake_exit
      TO_FLAG_CLR_I <= 1'b1;
      WDT_EN_CFG_I <= 1'b1;
      tick(1);
      TO_FLAG_CLR_I <= 1'b0;
      gap(1'b1, 1'b0);
      i_wwdt_core_model.send(5'h10);
      exp_q.push_back(3'b011);
      i_wwdt_core_model.send(5'h08);
      tick(2);
      check({SLEEP_FLAG_O, IDLE_FLAG_O, TIMEOUT_FLAG_O}, 3'h4);
      i_wwdt_core_model.send(5'h10);
      wait_evt();
      tick(2);
      check(3'(SLEEP_FLAG_O), 3'h1);
      SLEEP_FLAG_CLR_I <= 1'b1; // Software clears after waking
      tick(1);
      SLEEP_FLAG_CLR_I <= 1'b0;
      i_wwdt_core_model.send(5'h0c);
      tick(2);
      check({SLEEP_FLAG_O, IDLE_FLAG_O, 1'b0}, 3'h2);
      i_wwdt_core_model.send(5'h02);
      IDLE_FLAG_CLR_I <= 1'b1;
      tick(1);
      IDLE_FLAG_CLR_I <= 1'b0;
      tick(2);
      check(3'(IDLE_FLAG_O), 3'h0);
      $display("test sleep done");
      tick(10);
      conclude();
   end
endmodule
bind wwdt_top wwdt_assertions i_wwdt_assertions (.MCLK_I, .SRST_I,
   .DEV_RST_I, .CONFIG_WORD_ONE_I, .WDT_EN_CFG_I, .CPU_I, .SW_ON_WR_I,
   .SW_ON_DATA_I, .TO_FLAG_CLR_I, .WDT_RESET_O, .WAKE_O, .TIMEOUT_FLAG_O,
   .SLEEP_FLAG_O, .IDLE_FLAG_O, .SW_ON_O, .LOW_POWER_RC_OSC_ON_O, .RUNNING_O);
